// ===== hdl/bms_pkg.sv
// bms_pkg: constants, encodings and states of the boot monitor sequencer.
// assumes one 100 MHz clock and a synchronous active-low reset at the user.
package bms_pkg;

  // ==========================================================================
  // trap vectors and control memory addresses
  localparam logic [15:0] VEC_FETCH_PARITY = 16'h8000;
  localparam logic [15:0] VEC_RESET_KEY = 16'h8001;
  localparam logic [15:0] VEC_DATA_PARITY = 16'h8002;
  localparam logic [15:0] VEC_POWER_ON = 16'h8003;
  localparam logic [15:0] BAD_PARITY_WORD = 16'h800F;
  localparam logic [15:0] PROGRAM_START = 16'h3000;
  localparam logic [15:0] LOADABLE_TOP = 16'h7FFF;
  localparam logic [15:0] BOOT_BASE = 16'h8000;
  localparam logic [15:0] BOOT_TOP = 16'h83FF;
  localparam logic [15:0] PARITY_RET_ADDR = 16'h8010;

  // ==========================================================================
  // device addresses and display
  localparam logic [7:0] KEYBOARD_DEV = 8'h01;
  localparam logic [7:0] CRT_DEV = 8'h05;
  localparam logic [1:0] ERROR_PROMPT_LINE = 2'h2;
  localparam logic [3:0] INIT_STEP_LAST = 4'hE;
  localparam logic [3:0] PARITY_TEST_STEP = 4'h1;

  // ==========================================================================
  // function key choices
  localparam logic [4:0] KEY_RESUME = 5'h0F;
  localparam logic [4:0] KEY_LANG_A_LO = 5'h00;
  localparam logic [4:0] KEY_LANG_A_HI = 5'h05;
  localparam logic [4:0] KEY_LANG_B_LO = 5'h08;
  localparam logic [4:0] KEY_LANG_B_HI = 5'h0D;
  localparam logic [4:0] KEY_USER_LO = 5'h10;
  localparam logic [4:0] KEY_USER_HI = 5'h13;
  localparam logic [4:0] KEY_FIELD_LO = 5'h1C;
  localparam logic [4:0] KEY_FIELD_HI = 5'h1F;
  localparam logic [3:0] LANG_B_SLOT_BASE = 4'h6;

  // ==========================================================================
  // fault class codes and bank encodings
  localparam logic [2:0] FAULT_NONE = 3'h0;
  localparam logic [2:0] CONTROL_PARITY_FAULT_CODE = 3'h1;
  localparam logic [2:0] DATA_PARITY_FAULT_CODE = 3'h2;
  localparam logic [2:0] CONTROL_VERIFY_FAULT_CODE = 3'h3;
  localparam logic [2:0] DATA_VERIFY_FAULT_CODE = 3'h4;
  localparam logic [2:0] DISK_FAULT_CODE = 3'h5;
  localparam logic [7:0] BANK_CODE_STEP = 8'h40;
  localparam logic [7:0] DISK_CODE_HI = 8'h00;
  localparam logic [7:0] PROMPT_PARITY_CHAR = 8'h50;

  typedef enum {
    ST_IDLE, ST_INIT, ST_INIT_DONE, ST_KEY_WAIT, ST_DISK_SEARCH, ST_LOAD,
    ST_VERIFY_CM, ST_VERIFY_DM, ST_MENU, ST_MENU_KEY, ST_RUN, ST_ERROR
  } bms_state_t;

  typedef enum {
    KC_NONE, KC_RESUME, KC_LANG, KC_USER, KC_FIELD
  } bms_key_class_t;

endpackage

// ===== hdl/bms_key_decode.sv
// bms_key_decode: maps a function key choice to an action and disk slot.
// assumes a stable key code; purely combinational, registered by the user.
module bms_key_decode
  import bms_pkg::*;
(
  // key in
  input wire logic [4:0] key_code,
  // decoded
  output bms_key_class_t key_class,
  output logic [3:0] disk_slot
);

  // ==========================================================================
  // decode
  always_comb begin
    key_class = KC_NONE;
    disk_slot = 4'h0;
    if (key_code == KEY_RESUME) begin
      key_class = KC_RESUME;
    end else if (key_code <= KEY_LANG_A_HI) begin
      key_class = KC_LANG;
      disk_slot = key_code[3:0];
    end else if (key_code >= KEY_LANG_B_LO && key_code <= KEY_LANG_B_HI) begin
      key_class = KC_LANG;
      disk_slot = 4'(key_code[3:0] - KEY_LANG_B_LO[3:0] + LANG_B_SLOT_BASE);
    end else if (key_code >= KEY_USER_LO && key_code <= KEY_USER_HI) begin
      key_class = KC_USER;
      disk_slot = {2'b00, key_code[1:0]};
    end else if (key_code >= KEY_FIELD_LO && key_code <= KEY_FIELD_HI) begin
      key_class = KC_FIELD;
      disk_slot = {2'b00, key_code[1:0]};
    end
  end

endmodule

// ===== hdl/bms_top.sv
// bms_top: boot monitor sequencer entered by power-on, reset key and parity traps.
// assumes the processor core reports step results and memory/disk status as
// one-cycle pulses on CLK; console text is emitted one character per pulse.
// Notes on behaviour
// - power-on traps to 8003, starts initialization
// - execute bad-parity word 800F, check trap
// - fifteen init steps in order, prompt each
// - reset: clear, prompt, keyboard 01, repeat
// - valid key: enable disk, search file
// - load parity error: show P, reload
// - verify control then data memory
// - all checks pass: jump to 3000
// - menu path: menu, key, file search
// - memory fault: four-class code plus detail, except control verify: boot-area flag, no detail
// - disk fault: code with zero upper byte
// - every error prompts reset on line 2
// - key 15 resumes loaded program
// - language keys map twelve disk addresses
// - diagnostic keys map four disk addresses
// - fetch parity fault traps to 8000
// - verify address classifies loadable or boot
// - reset key traps to 8001
// - data byte parity generated; read traps 8002
// - data bank encoded 00/40/80/C0
module bms_top
  import bms_pkg::*;
(
  // clock and reset
  input wire logic CLK,
  input wire logic NRST,
  // traps
  input wire logic POWER_ON,
  input wire logic RESET_KEY,
  // instruction fetch
  input wire logic FETCH_VALID,
  input wire logic [23:0] FETCH_WORD,
  input wire logic [15:0] FETCH_ADDR,
  input wire logic [23:0] REREAD_WORD,
  // data memory
  input wire logic DM_WRITE,
  input wire logic [7:0] DM_WDATA,
  input wire logic DM_READ,
  input wire logic [8:0] DM_RDATA,
  input wire logic [1:0] DM_BANK,
  input wire logic [15:0] DM_ADDR,
  // self-test results
  input wire logic STEP_DONE,
  input wire logic STEP_PASS,
  input wire logic [15:0] TRAP_RET_ADDR,
  // keyboard
  input wire logic KEY_VALID,
  input wire logic [4:0] KEY_CODE,
  // disk
  input wire logic DISK_FOUND,
  input wire logic DISK_ABSENT,
  input wire logic DISK_ERROR,
  input wire logic [7:0] DISK_ERR_CODE,
  input wire logic LOAD_DONE,
  input wire logic LOAD_PARITY_ERR,
  input wire logic LOAD_HAS_CM,
  // verify
  input wire logic VERIFY_DONE,
  input wire logic VERIFY_FAIL,
  input wire logic [15:0] VERIFY_ADDR,
  // control out
  output logic [15:0] BRANCH_ADDR,
  output logic BRANCH,
  output logic EXEC_ENABLE,
  output logic [3:0] INIT_STEP,
  output logic [8:0] DM_WDATA_PAR,
  // console out
  output logic [7:0] IO_DEV,
  output logic IO_ENABLE,
  output logic CLEAR_SCREEN,
  output logic CHAR_STROBE,
  output logic [7:0] CHAR_OUT,
  output logic [1:0] SCREEN_LINE,
  // disk out
  output logic DISK_ENABLE,
  output logic [3:0] DISK_SLOT,
  output logic RELOAD_SECTOR,
  output logic MENU_LOAD,
  // fault report
  output logic [2:0] FAULT_CLASS,
  output logic [15:0] FAULT_ADDR,
  output logic [23:0] FAULT_DETAIL,
  output logic FAULT_BOOT_AREA
);

  // ==========================================================================
  // helpers
  function automatic logic odd_ok(input logic [23:0] w);
    return ^w;
  endfunction

  function automatic logic [7:0] bank_code(input logic [1:0] b);
    return 8'(b * BANK_CODE_STEP);
  endfunction

  bms_state_t state_reg;
  bms_state_t state_next;
  logic resume_ok_reg;
  logic parity_test_reg;
  bms_key_class_t key_class;
  logic [3:0] key_slot;
  logic fetch_bad;
  logic data_bad;
  logic step_ok;

  bms_key_decode u_key (
    .key_code(KEY_CODE),
    .key_class(key_class),
    .disk_slot(key_slot)
  );

  // checked combinationally on the fetched word so a bad word is trapped before it executes
  assign fetch_bad = FETCH_VALID && !odd_ok(FETCH_WORD);
  assign data_bad = DM_READ && !odd_ok({15'h0000, DM_RDATA});
  // trap test step passes only once the trap fired with the right return
  assign step_ok = STEP_PASS && (INIT_STEP != PARITY_TEST_STEP || parity_test_reg);

  // ==========================================================================
  // sequencer
  always_comb begin
    state_next = state_reg;
    if (POWER_ON) begin
      state_next = ST_INIT;
    end else if (RESET_KEY) begin
      state_next = ST_KEY_WAIT;
    end else if ((fetch_bad || data_bad) && state_reg != ST_INIT) begin
      state_next = ST_ERROR;
    end else begin
      case (state_reg)
        ST_INIT: begin
          if (STEP_DONE && !step_ok) begin
            state_next = ST_IDLE;
          end else if (STEP_DONE && INIT_STEP == INIT_STEP_LAST) begin
            state_next = ST_INIT_DONE;
          end
        end
        ST_KEY_WAIT: begin
          if (KEY_VALID && key_class == KC_RESUME && resume_ok_reg) begin
            state_next = ST_RUN;
          end else if (KEY_VALID && key_class != KC_NONE && key_class != KC_RESUME) begin
            state_next = ST_DISK_SEARCH;
          end
        end
        ST_DISK_SEARCH: begin
          if (DISK_ERROR) begin
            state_next = ST_ERROR;
          end else if (DISK_ABSENT) begin
            state_next = ST_KEY_WAIT;
          end else if (DISK_FOUND) begin
            state_next = ST_LOAD;
          end
        end
        ST_LOAD: begin
          if (DISK_ERROR) begin
            state_next = ST_ERROR;
          end else if (LOAD_DONE && !LOAD_HAS_CM) begin
            state_next = ST_MENU;
          end else if (LOAD_DONE) begin
            state_next = ST_VERIFY_CM;
          end
        end
        ST_VERIFY_CM: begin
          if (VERIFY_DONE) begin
            state_next = VERIFY_FAIL ? ST_ERROR : ST_VERIFY_DM;
          end
        end
        ST_VERIFY_DM: begin
          if (VERIFY_DONE) begin
            state_next = VERIFY_FAIL ? ST_ERROR : ST_RUN;
          end
        end
        ST_MENU: state_next = ST_MENU_KEY;
        ST_MENU_KEY: begin
          if (KEY_VALID && key_class != KC_NONE && key_class != KC_RESUME) begin
            state_next = ST_DISK_SEARCH;
          end
        end
        ST_IDLE, ST_INIT_DONE, ST_RUN, ST_ERROR: state_next = state_reg;
        default: state_next = ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge CLK) begin
    if (!NRST) begin
      state_reg <= ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // ==========================================================================
  // init step counter and parity trap self-test
  always_ff @(posedge CLK) begin
    if (!NRST || POWER_ON) begin
      INIT_STEP <= 4'h0;
      parity_test_reg <= 1'b0;
    end else if (state_reg == ST_INIT && STEP_DONE && step_ok && INIT_STEP != INIT_STEP_LAST) begin
      INIT_STEP <= 4'(INIT_STEP + 4'h1);
      parity_test_reg <= 1'b0;
    end else if (state_reg == ST_INIT && INIT_STEP == PARITY_TEST_STEP && fetch_bad
        && FETCH_ADDR == BAD_PARITY_WORD && TRAP_RET_ADDR == PARITY_RET_ADDR) begin
      parity_test_reg <= 1'b1;
    end
  end

  // program present once a verified load ran
  always_ff @(posedge CLK) begin
    if (!NRST || POWER_ON) begin
      resume_ok_reg <= 1'b0;
    end else if (state_reg == ST_VERIFY_DM && VERIFY_DONE && !VERIFY_FAIL) begin
      resume_ok_reg <= 1'b1;
    end else if (state_reg == ST_LOAD) begin
      resume_ok_reg <= 1'b0;
    end
  end

  // ==========================================================================
  // branch and execute control
  always_ff @(posedge CLK) begin
    if (!NRST) begin
      BRANCH <= 1'b0;
      BRANCH_ADDR <= VEC_POWER_ON;
      EXEC_ENABLE <= 1'b0;
    end else begin
      BRANCH <= 1'b0;
      EXEC_ENABLE <= (state_next == ST_RUN);
      if (POWER_ON) begin
        BRANCH <= 1'b1;
        BRANCH_ADDR <= VEC_POWER_ON;
      end else if (RESET_KEY) begin
        BRANCH <= 1'b1;
        BRANCH_ADDR <= VEC_RESET_KEY;
      end else if (fetch_bad) begin
        BRANCH <= 1'b1;
        BRANCH_ADDR <= VEC_FETCH_PARITY;
        EXEC_ENABLE <= 1'b0;
      end else if (data_bad) begin
        BRANCH <= 1'b1;
        BRANCH_ADDR <= VEC_DATA_PARITY;
      end else if (state_reg != ST_RUN && state_next == ST_RUN) begin
        BRANCH <= 1'b1;
        BRANCH_ADDR <= PROGRAM_START;
      end
    end
  end

  // odd parity ninth bit on every data byte write
  always_ff @(posedge CLK) begin
    if (!NRST) begin
      DM_WDATA_PAR <= 9'h000;
    end else if (DM_WRITE) begin
      DM_WDATA_PAR <= {~^DM_WDATA, DM_WDATA};
    end
  end

  // ==========================================================================
  // console and disk outputs
  always_ff @(posedge CLK) begin
    if (!NRST) begin
      IO_DEV <= CRT_DEV;
      IO_ENABLE <= 1'b0;
      CLEAR_SCREEN <= 1'b0;
      CHAR_STROBE <= 1'b0;
      CHAR_OUT <= 8'h00;
      SCREEN_LINE <= 2'h1;
      DISK_ENABLE <= 1'b0;
      DISK_SLOT <= 4'h0;
      RELOAD_SECTOR <= 1'b0;
      MENU_LOAD <= 1'b0;
    end else begin
      CLEAR_SCREEN <= 1'b0;
      CHAR_STROBE <= 1'b0;
      RELOAD_SECTOR <= 1'b0;
      if (POWER_ON || RESET_KEY) begin
        CLEAR_SCREEN <= 1'b1;
        SCREEN_LINE <= 2'h1;
        IO_DEV <= CRT_DEV;
        IO_ENABLE <= 1'b1;
      end else if (state_next == ST_ERROR && state_reg != ST_ERROR) begin
        SCREEN_LINE <= ERROR_PROMPT_LINE;
        CHAR_STROBE <= 1'b1;
        IO_DEV <= CRT_DEV;
      end else if (state_reg == ST_INIT && STEP_DONE && step_ok) begin
        CHAR_STROBE <= 1'b1;
        CHAR_OUT <= {4'h0, INIT_STEP};
      end else if (state_reg == ST_KEY_WAIT || state_reg == ST_MENU_KEY) begin
        IO_DEV <= KEYBOARD_DEV;
        IO_ENABLE <= 1'b1;
        if (KEY_VALID && key_class == KC_NONE) begin
          CHAR_STROBE <= 1'b1;
        end
      end else if (state_reg == ST_LOAD && LOAD_PARITY_ERR) begin
        CHAR_STROBE <= 1'b1;
        CHAR_OUT <= PROMPT_PARITY_CHAR;
        RELOAD_SECTOR <= 1'b1;
      end else if (state_reg == ST_MENU) begin
        CHAR_STROBE <= 1'b1;
      end
      if (KEY_VALID && (state_reg == ST_KEY_WAIT || state_reg == ST_MENU_KEY) && key_class != KC_NONE
          && key_class != KC_RESUME) begin
        DISK_ENABLE <= 1'b1;
        DISK_SLOT <= key_slot;
        MENU_LOAD <= (key_class == KC_USER || key_class == KC_FIELD);
      end else if (state_reg == ST_RUN || state_reg == ST_ERROR || state_reg == ST_KEY_WAIT
          || state_reg == ST_MENU) begin
        DISK_ENABLE <= 1'b0;
      end
    end
  end

  // ==========================================================================
  // fault report capture; the detail word is the reread, not the faulted fetch
  always_ff @(posedge CLK) begin
    if (!NRST || POWER_ON) begin
      FAULT_CLASS <= FAULT_NONE;
      FAULT_ADDR <= 16'h0000;
      FAULT_DETAIL <= 24'h000000;
      FAULT_BOOT_AREA <= 1'b0;
    end else if (fetch_bad && state_reg != ST_INIT) begin
      FAULT_CLASS <= CONTROL_PARITY_FAULT_CODE;
      FAULT_ADDR <= FETCH_ADDR;
      FAULT_DETAIL <= REREAD_WORD;
    end else if (data_bad && state_reg != ST_INIT) begin
      FAULT_CLASS <= DATA_PARITY_FAULT_CODE;
      FAULT_ADDR <= DM_ADDR;
      FAULT_DETAIL <= {16'h0000, bank_code(DM_BANK)};
    end else if (state_reg == ST_VERIFY_CM && VERIFY_DONE && VERIFY_FAIL) begin
      FAULT_CLASS <= CONTROL_VERIFY_FAULT_CODE;
      FAULT_ADDR <= VERIFY_ADDR;
      FAULT_BOOT_AREA <= VERIFY_ADDR >= BOOT_BASE && VERIFY_ADDR <= BOOT_TOP;
    end else if (state_reg == ST_VERIFY_DM && VERIFY_DONE && VERIFY_FAIL) begin
      FAULT_CLASS <= DATA_VERIFY_FAULT_CODE;
      FAULT_ADDR <= VERIFY_ADDR;
      FAULT_DETAIL <= {16'h0000, bank_code(DM_BANK)};
    end else if ((state_reg == ST_LOAD || state_reg == ST_DISK_SEARCH) && DISK_ERROR) begin
      FAULT_CLASS <= DISK_FAULT_CODE;
      FAULT_ADDR <= {DISK_CODE_HI, DISK_ERR_CODE};
    end
  end

  // ==========================================================================
  // checks
  property p_fetch_trap;
    @(posedge CLK) disable iff (!NRST)
    (fetch_bad && !POWER_ON && !RESET_KEY) |=> BRANCH && BRANCH_ADDR == VEC_FETCH_PARITY && !EXEC_ENABLE;
  endproperty
  a_fetch_trap: assert property (p_fetch_trap) else $error("fetch parity trap missed");

  property p_reset_vec;
    @(posedge CLK) disable iff (!NRST) (RESET_KEY && !POWER_ON) |=> BRANCH_ADDR == VEC_RESET_KEY && CLEAR_SCREEN;
  endproperty
  a_reset_vec: assert property (p_reset_vec) else $error("reset trap wrong");

  property p_power_vec;
    @(posedge CLK) disable iff (!NRST) POWER_ON |=> BRANCH_ADDR == VEC_POWER_ON && INIT_STEP == 4'h0;
  endproperty
  a_power_vec: assert property (p_power_vec) else $error("power trap wrong");

  property p_dm_par;
    @(posedge CLK) disable iff (!NRST) DM_WRITE |=> ^DM_WDATA_PAR && DM_WDATA_PAR[7:0] == $past(DM_WDATA);
  endproperty
  a_dm_par: assert property (p_dm_par) else $error("data parity not odd");

  sequence s_load_perr;
    state_reg == ST_LOAD && LOAD_PARITY_ERR && !DISK_ERROR && !LOAD_DONE && !POWER_ON && !RESET_KEY
      && !fetch_bad && !data_bad;
  endsequence
  property p_load_perr;
    @(posedge CLK) disable iff (!NRST) s_load_perr |=> RELOAD_SECTOR && CHAR_OUT == PROMPT_PARITY_CHAR;
  endproperty
  a_load_perr: assert property (p_load_perr) else $error("load parity reload missing");

  property p_run_start;
    @(posedge CLK) disable iff (!NRST) $rose(EXEC_ENABLE) |-> BRANCH && BRANCH_ADDR == PROGRAM_START;
  endproperty
  a_run_start: assert property (p_run_start) else $error("run not at 3000");

  property p_err_line;
    @(posedge CLK) disable iff (!NRST) (state_reg != ST_ERROR ##1 state_reg == ST_ERROR) |-> SCREEN_LINE == ERROR_PROMPT_LINE;
  endproperty
  a_err_line: assert property (p_err_line) else $error("error prompt not on line 2");

  property p_disk_code;
    @(posedge CLK) disable iff (!NRST) FAULT_CLASS == DISK_FAULT_CODE |-> FAULT_ADDR[15:8] == DISK_CODE_HI;
  endproperty
  a_disk_code: assert property (p_disk_code) else $error("disk code upper byte nonzero");

endmodule

// ===== verification/bms_disk_model.sv
// bms_disk_model: behavioural system disk that answers file search and load.
// assumes the bench sets reply mode and latency before the drive is enabled.
module bms_disk_model (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // from the monitor
  input wire logic disk_enable,
  // reply mode from the bench
  input wire logic [3:0] lat,
  input wire logic found,
  input wire logic perr,
  input wire logic has_cm,
  input wire logic err,
  input wire logic [7:0] code,
  // to the monitor
  output logic disk_found,
  output logic disk_absent,
  output logic disk_error,
  output logic [7:0] disk_err_code,
  output logic load_done,
  output logic load_parity_err,
  output logic load_has_cm
);
  timeunit 1ns;
  timeprecision 1ps;

  logic en_q = 1'b0;
  logic [4:0] ev = 5'h00;

  assign {disk_found, disk_absent, disk_error, load_done, load_parity_err} = ev;

  initial disk_err_code = 8'h00;
  initial load_has_cm = 1'b0;

  always @(posedge clk) en_q <= disk_enable;

  task fire(input int i);
    repeat (lat) @(posedge clk);
    #1;
    ev[i] = 1'b1;
    @(posedge clk);
    #1;
    ev[i] = 1'b0;
  endtask

  // ==========================================================================
  // one answer per rising enable; a held enable is not searched again
  always begin
    @(posedge clk iff (nrst && disk_enable && !en_q));
    if (!found) begin
      fire(3);
    end else begin
      fire(4);
      if (perr) begin
        fire(0);
      end
      if (err) begin
        disk_err_code = code;
        fire(2);
      end else begin
        load_has_cm = has_cm;
        fire(1);
      end
      // qualifiers are stale once the pulse is gone
      disk_err_code = ~code;
      load_has_cm = ~has_cm;
    end
  end
endmodule

// ===== verification/tb.sv
// tb: self-checking bench for the boot monitor sequencer.
// assumes bms_disk_model stands in for the disk; keys and core results come from here.
module tb;
  import bms_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  logic clk = 0, nrst = 0, pwr = 0, rkey = 0, fv = 0, dmw = 0, dmr = 0, sd = 0, sp = 1, kv = 0, vd = 0, vf = 0;
  logic [23:0] fw = 0, rw = 0;
  logic [15:0] fa = 0, va = 0, baddr, faddr;
  logic [15:0] ret = PARITY_RET_ADDR;
  logic [8:0] dmrd = 0, wpar;
  logic [7:0] dmwd = 0, dcode = 0, dcode_o, iodev, chout;
  logic [4:0] kc = 0;
  logic [3:0] lat = 0, istep, slot;
  logic [2:0] fcls;
  logic [1:0] bank = 0, line;
  logic found = 0, perr = 0, hcm = 1, derr = 0, seen_ld = 0, seen_abs = 0;
  logic dfound, dabs, derr_o, ldone, lperr, lhcm, br, exe, ioen, clr, cst, den, rel, mload, fboot;
  logic [23:0] fdet;
  int n_fail = 0, checks = 0;

  always #5 clk = ~clk;

  bms_top bms_top_inst (.CLK(clk), .NRST(nrst), .POWER_ON(pwr), .RESET_KEY(rkey), .FETCH_VALID(fv),
    .FETCH_WORD(fw), .FETCH_ADDR(fa), .REREAD_WORD(rw), .DM_WRITE(dmw), .DM_WDATA(dmwd), .DM_READ(dmr),
    .DM_RDATA(dmrd), .DM_BANK(bank), .DM_ADDR(16'h0040), .STEP_DONE(sd), .STEP_PASS(sp),
    .TRAP_RET_ADDR(ret), .KEY_VALID(kv), .KEY_CODE(kc), .DISK_FOUND(dfound),
    .DISK_ABSENT(dabs), .DISK_ERROR(derr_o), .DISK_ERR_CODE(dcode_o), .LOAD_DONE(ldone),
    .LOAD_PARITY_ERR(lperr), .LOAD_HAS_CM(lhcm), .VERIFY_DONE(vd), .VERIFY_FAIL(vf), .VERIFY_ADDR(va),
    .BRANCH_ADDR(baddr), .BRANCH(br), .EXEC_ENABLE(exe), .INIT_STEP(istep), .DM_WDATA_PAR(wpar),
    .IO_DEV(iodev), .IO_ENABLE(ioen), .CLEAR_SCREEN(clr), .CHAR_STROBE(cst), .CHAR_OUT(chout),
    .SCREEN_LINE(line), .DISK_ENABLE(den), .DISK_SLOT(slot), .RELOAD_SECTOR(rel), .MENU_LOAD(mload),
    .FAULT_CLASS(fcls), .FAULT_ADDR(faddr), .FAULT_DETAIL(fdet), .FAULT_BOOT_AREA(fboot));

  bms_disk_model bms_disk_model_inst (.clk(clk), .nrst(nrst), .disk_enable(den), .lat(lat), .found(found),
    .perr(perr), .has_cm(hcm), .err(derr), .code(dcode), .disk_found(dfound), .disk_absent(dabs),
    .disk_error(derr_o), .disk_err_code(dcode_o), .load_done(ldone), .load_parity_err(lperr),
    .load_has_cm(lhcm));

  // partner pulses land off the edge, so latch them at the edge
  always @(posedge clk) begin
    if (ldone) seen_ld = 1;
    if (dabs) seen_abs = 1;
  end

  // ==========================================================================
  // shared tasks
  task tick;
    @(posedge clk);
    #1;
  endtask

  task chk(input string nm, input logic [23:0] seen, input logic [23:0] exp);
    checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task test_done;
    $display("checks %0d mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  function automatic logic sig(input int s);
    case (s)
      0: return br;
      1: return den;
      2: return exe;
      3: return cst;
      4: return rel;
      5: return mload;
      6: return seen_ld;
      7: return cst && line === ERROR_PROMPT_LINE;
      9: return seen_abs;
      10: return cst && chout === PROMPT_PARITY_CHAR;
      default: return iodev === KEYBOARD_DEV && ioen;
    endcase
  endfunction

  task await(input int s);
    for (int i = 0; i < 300; i++) begin
      if (sig(s) === 1'b1) return;
      tick;
    end
    n_fail++;
    $display("ERROR timeout on event %0d", s);
    test_done;
  endtask

  // one-cycle request: 0 power 1 reset key 2 fetch 3 dm write 4 dm read 5 step 6 key 7 verify
  task pulse(input int w);
    case (w)
      0: pwr = 1;
      1: rkey = 1;
      2: fv = 1;
      3: dmw = 1;
      4: dmr = 1;
      5: sd = 1;
      6: kv = 1;
      default: vd = 1;
    endcase
    @(posedge clk);
    {pwr, rkey, fv, dmw, dmr, sd, kv, vd} <= '0;
    #1;
  endtask

  task key(input logic [4:0] c);
    kc = c;
    pulse(6);
  endtask

  task verify(input logic f, input logic [15:0] a);
    vf = f;
    va = a;
    pulse(7);
  endtask

  task rst_key;
    pulse(1);
    await(0);
    chk("reset vector", baddr, VEC_RESET_KEY);
    chk("clear screen", clr, 1);
    await(8);
  endtask

  // ==========================================================================
  // scenarios
  task sc_init;
    pulse(0);
    await(0);
    chk("power vector", baddr, VEC_POWER_ON);
    for (int s = 0; s < 15; s++) begin
      chk("init step", istep, 24'(s));
      if (s == 1) begin
        fa = BAD_PARITY_WORD;
        fw = 24'h000000;
        ret = 16'h0000;
        pulse(2);
        pulse(5);
        chk("bad return fails step", {cst, istep}, 5'h01);
        ret = PARITY_RET_ADDR;
        pulse(0);
        pulse(5);
        pulse(2);
        chk("self trap", br, 1);
        chk("self trap vector", baddr, VEC_FETCH_PARITY);
        chk("self trap no fault", fcls, FAULT_NONE);
      end
      pulse(5);
      await(3);
    end
  endtask

  task sc_keys;
    logic [3:0] sl;
    rst_key;
    key(5'h06);
    await(3);
    chk("bad key no disk", den, 0);
    found = 0;
    for (int k = 0; k < 32; k++) begin
      if (k <= 5) sl = 4'(k);
      else if (k >= 8 && k <= 13) sl = 4'(k - 2);
      else if (k >= 16 && k <= 19) sl = 4'(k - 16);
      else if (k >= 28) sl = 4'(k - 28);
      else continue;
      seen_abs = 0;
      key(5'(k));
      await(1);
      chk("disk slot", slot, sl);
      await(9);
      tick;
      tick;
      chk("absent file back to key wait", den, 0);
    end
  endtask

  task sc_load;
    rst_key;
    found = 1;
    perr = 1;
    lat = 4'h5;
    seen_ld = 0;
    key(KEY_LANG_B_LO);
    await(4);
    await(10);
    perr = 0;
    await(6);
    verify(0, 16'h0000);
    chk("no jump before data check", br, 0);
    verify(0, 16'h0000);
    await(0);
    chk("program start", baddr, PROGRAM_START);
    chk("running", exe, 1);
    rst_key;
    key(KEY_RESUME);
    await(2);
    chk("resume without disk", den, 0);
  endtask

  task sc_faults;
    dmwd = 8'hA5;
    pulse(3);
    chk("dm write parity", wpar, 9'h1A5);
    dmrd = 9'h1A5;
    pulse(4);
    chk("good read no trap", br, 0);
    dmrd = 9'h0A5;
    bank = 2'h2;
    pulse(4);
    chk("data trap", baddr, VEC_DATA_PARITY);
    chk("data class", fcls, DATA_PARITY_FAULT_CODE);
    chk("bank code", fdet[7:0], 8'h80);
    chk("data address", faddr, 16'h0040);
    rst_key;
    key(KEY_RESUME);
    await(2);
    fa = 16'h1234;
    rw = 24'hABCDEF;
    fw = 24'h800000; // lone bit 23 keeps the word odd
    pulse(2);
    chk("good word no trap", br, 0);
    fw = 24'h800001;
    pulse(2);
    chk("trap before execute", br, 1);
    chk("halted", exe, 0);
    chk("fetch vector", baddr, VEC_FETCH_PARITY);
    chk("fetch class", fcls, CONTROL_PARITY_FAULT_CODE);
    chk("fault address", faddr, 16'h1234);
    chk("reread word", fdet, 24'hABCDEF);
    chk("prompt line", line, ERROR_PROMPT_LINE);
  endtask

  task sc_disk;
    rst_key;
    derr = 1;
    dcode = 8'h93;
    key(KEY_LANG_A_LO);
    await(7);
    chk("disk class", fcls, DISK_FAULT_CODE);
    chk("disk code", faddr, 16'h0093);
    chk("disk prompt line", line, ERROR_PROMPT_LINE);
    derr = 0;
    for (int m = 0; m < 3; m++) begin
      rst_key;
      seen_ld = 0;
      key(KEY_LANG_A_LO);
      await(6);
      verify(m < 2, m == 0 ? 16'h0100 : 16'h8100);
      if (m == 2) verify(1, 16'h0042);
      await(7);
      chk("verify class", fcls, m < 2 ? CONTROL_VERIFY_FAULT_CODE : DATA_VERIFY_FAULT_CODE);
      if (m < 2) chk("boot area", fboot, m == 1);
    end
    rst_key;
    hcm = 0;
    seen_ld = 0;
    key(KEY_USER_LO);
    await(5);
    await(6);
    await(3);
    await(8);
    key(KEY_USER_HI);
    await(1);
    chk("menu key slot", slot, 4'h3);
  endtask

  initial begin
    repeat (10) @(posedge clk);
    #1;
    chk("reset vector value", baddr, VEC_POWER_ON);
    nrst = 1;
    sc_init;
    sc_keys;
    sc_load;
    sc_faults;
    sc_disk;
    test_done;
  end
endmodule
